/* File: verilog/fan_cfg_pkg.sv */
package fan_cfg_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SMOOTH_CFG = 8'h10;
    localparam logic [7:0] IDX_HYST_CFG = 8'h11;
    localparam logic [7:0] IDX_LOCK = 8'h12;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h13;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h14;
    localparam logic [7:0] IDX_STATE = 8'h15;
    localparam int ADDR_LSB = 2;
    localparam int BASE_W = 8;
    localparam int SCALED_W = 11;
    localparam int NUM_CH = 3;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] SMOOTH_WMASK = 8'hcf;
    localparam logic [7:0] HYST_WMASK = 8'h01;
    // Status and mask bit positions
    localparam int ST_OVERTEMP = 0;
    localparam int ST_CORE_LOW = 1;
    localparam int ST_W = 2;
    // Slow mode multiplies by four: shift by two
    localparam int SLOW_SHIFT = 2;
    // 1.392 in Q10 fixed point, floor(1.392 * 1024)
    localparam logic [10:0] EXTRA_Q10 = 11'h591;
    localparam int EXTRA_FRAC = 10;
    // Spin-up time after the core voltage recovers
    localparam int SPINUP_US = 2000;
    localparam int CLK_MHZ = 100;
    localparam int SPINUP_CYCLES = SPINUP_US * CLK_MHZ;
    localparam int SPIN_CNT_W = 24;

    typedef struct packed {
        logic global_smoothing_extra_stretch;
        logic core_low_standby_handling;
        logic [1:0] reserved;
        logic overtemp_in_manual_mode;
        logic [NUM_CH-1:0] slow;
    } smooth_cfg_t;

    typedef enum logic [1:0] {MON_RUN, MON_CORE_LOW, MON_SPINUP} mon_state_t;
endpackage : fan_cfg_pkg

/* File: verilog/smooth_scale.sv */
`timescale 1ns/1ps
// One channel's smoothing time with its stretch factors applied
module smooth_scale
    import fan_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [BASE_W-1:0] base_time,
    input wire logic slow,
    input wire logic extra,
    output logic [SCALED_W-1:0] scaled_time
);
    logic [SCALED_W-1:0] slowed;
    logic [SCALED_W+EXTRA_FRAC:0] product;

    // Both factors stack when both are on
    always_comb begin
        slowed = slow ? (SCALED_W'(base_time) << SLOW_SHIFT) : SCALED_W'(base_time);
        product = (SCALED_W + EXTRA_FRAC + 1)'(slowed) * EXTRA_Q10;
    end

    // Truncation keeps the stretched time a touch short rather than long
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scaled_time <= '0;
        end else if (ce) begin
            scaled_time <= extra ? product[EXTRA_FRAC +: SCALED_W] : slowed;
        end
    end
endmodule : smooth_scale

/* File: verilog/fan_smoothing_overtemp_config.sv */
`timescale 1ns/1ps
// Behaviour
// - Bit0 quadruples fan 1 remote-1 smoothing
// - Bit1 quadruples fan 2 local smoothing
// - Bit2 quadruples fan 3 remote-2 smoothing
// - Bit3 keeps overtemp pin active in manual
// - Overtemp overrides every fan setting, even disabled; in manual mode only with bit3 set
// - Standby core-low sets status bit1, alerts
// - Core-low suspends processor-hot monitoring
// - Recovery re-enables monitoring and starts spin-up in the same cycle
// - Bit7 stretches all smoothing by 39.2 percent
// - Hysteresis register bit0 disables overtemp hysteresis
// - Lock makes hysteresis register read-only
// - Both configuration registers reset to zero
module fan_smoothing_overtemp_config
    import fan_cfg_pkg::*;
#(
    parameter int SPINUP_LEN = SPINUP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [BASE_W-1:0] base_time_remote1,
    input wire logic [BASE_W-1:0] base_time_local,
    input wire logic [BASE_W-1:0] base_time_remote2,
    input wire logic overtemp_pin,
    input wire logic manual_mode,
    input wire logic standby_power,
    input wire logic core_voltage_low,
    output logic [SCALED_W-1:0] smooth_time_remote1,
    output logic [SCALED_W-1:0] smooth_time_local,
    output logic [SCALED_W-1:0] smooth_time_remote2,
    output logic fan_override,
    output logic overtemp_hysteresis_on,
    output logic processor_hot_monitor,
    output logic fan_spinup,
    output logic irq
);
    smooth_cfg_t smooth_cfg_reg;
    logic [7:0] hyst_cfg_reg;
    logic lock_reg;
    logic [ST_W-1:0] status_reg;
    logic [ST_W-1:0] mask_reg;
    mon_state_t mon_state_reg;
    logic [SPIN_CNT_W-1:0] spin_cnt_reg;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic ot_pin_s, manual_s, standby_s, core_low_s;
    logic wr_en, rd_setup;
    logic [7:0] index;
    logic [31:0] rdata_next;
    logic mapped;
    logic ot_active, core_low_event;

    // Pins come from outside the clock domain: two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else if (ce) begin
            sync1_reg <= {core_voltage_low, standby_power, manual_mode, overtemp_pin};
            sync2_reg <= sync1_reg;
        end
    end
    assign {core_low_s, standby_s, manual_s, ot_pin_s} = sync2_reg;

    // Bus decode: index from the word address
    assign index = paddr[ADDR_LSB +: 8];
    assign wr_en = ce && psel && penable && pready && pwrite && !pslverr;
    assign rd_setup = psel && !penable;

    // Address decode and read mux
    always_comb begin
        mapped = 1'b1;
        rdata_next = '0;
        if (paddr[31:ADDR_LSB+8] != '0 || paddr[ADDR_LSB-1:0] != '0) begin
            mapped = 1'b0;
        end else if (index == IDX_SMOOTH_CFG) begin
            rdata_next[7:0] = smooth_cfg_reg;
        end else if (index == IDX_HYST_CFG) begin
            rdata_next[7:0] = hyst_cfg_reg;
        end else if (index == IDX_LOCK) begin
            rdata_next[0] = lock_reg;
        end else if (index == IDX_IRQ_STATUS) begin
            rdata_next[ST_W-1:0] = status_reg;
        end else if (index == IDX_IRQ_MASK) begin
            rdata_next[ST_W-1:0] = mask_reg;
        end else if (index == IDX_STATE) begin
            rdata_next[1:0] = mon_state_reg;
        end else begin
            mapped = 1'b0;
        end
    end

    // Zero-wait slave: answer prepared in setup, complete in first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (ce) begin
            pready <= rd_setup;
            pslverr <= rd_setup && !mapped;
            if (rd_setup) begin
                prdata <= pwrite ? '0 : rdata_next;
            end
        end
    end

    // Configuration registers; reserved bits are never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smooth_cfg_reg <= CFG_RESET;
            hyst_cfg_reg <= CFG_RESET;
        end else if (wr_en) begin
            if (index == IDX_SMOOTH_CFG) begin
                smooth_cfg_reg <= pwdata[7:0] & SMOOTH_WMASK;
            end else if (index == IDX_HYST_CFG && !lock_reg) begin
                hyst_cfg_reg <= pwdata[7:0] & HYST_WMASK;
            end
        end
    end

    // Lock is set-only; only reset releases it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_reg <= 1'b0;
        end else if (wr_en && index == IDX_LOCK && pwdata[0]) begin
            lock_reg <= 1'b1;
        end
    end

    // Overtemp acts in auto mode, and in manual mode only when allowed
    assign ot_active = ot_pin_s && (!manual_s || smooth_cfg_reg.overtemp_in_manual_mode);
    assign core_low_event = smooth_cfg_reg.core_low_standby_handling && standby_s && core_low_s;

    // Interrupt status: sticky, write one to clear, a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= '0;
            mask_reg <= '0;
        end else if (ce) begin
            if (wr_en && index == IDX_IRQ_MASK) begin
                mask_reg <= pwdata[ST_W-1:0];
            end
            for (int i = 0; i < ST_W; i++) begin
                if (wr_en && index == IDX_IRQ_STATUS && pwdata[i]) begin
                    status_reg[i] <= 1'b0;
                end
            end
            if (ot_active) begin
                status_reg[ST_OVERTEMP] <= 1'b1;
            end
            if (core_low_event) begin
                status_reg[ST_CORE_LOW] <= 1'b1;
            end
        end
    end

    // Level interrupt doubles as the alert line, gated by the mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(status_reg & mask_reg);
        end
    end

    // Core-voltage supervision: suspend, then spin up after recovery
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_state_reg <= MON_RUN;
            spin_cnt_reg <= '0;
        end else if (ce) begin
            case (mon_state_reg)
                MON_RUN: begin
                    if (core_low_event) begin
                        mon_state_reg <= MON_CORE_LOW;
                    end
                end
                MON_CORE_LOW: begin
                    if (!core_low_s) begin
                        mon_state_reg <= MON_SPINUP;
                        spin_cnt_reg <= SPIN_CNT_W'(SPINUP_LEN - 1);
                    end
                end
                MON_SPINUP: begin
                    if (core_low_event) begin
                        mon_state_reg <= MON_CORE_LOW;
                    end else if (spin_cnt_reg == '0) begin
                        mon_state_reg <= MON_RUN;
                    end else begin
                        spin_cnt_reg <= spin_cnt_reg - 1'b1;
                    end
                end
                default: begin
                    mon_state_reg <= MON_RUN;
                end
            endcase
        end
    end

    // Registered control outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan_override <= 1'b0;
            overtemp_hysteresis_on <= 1'b1;
            processor_hot_monitor <= 1'b1;
            fan_spinup <= 1'b0;
        end else if (ce) begin
            fan_override <= ot_active;
            overtemp_hysteresis_on <= !hyst_cfg_reg[0];
            processor_hot_monitor <= mon_state_reg != MON_CORE_LOW;
            fan_spinup <= mon_state_reg == MON_SPINUP;
        end
    end

    // One scaler per temperature channel
    smooth_scale u_scale_r1 (
        .pclk(pclk), .presetn(presetn), .ce(ce), .base_time(base_time_remote1),
        .slow(smooth_cfg_reg.slow[0]),
        .extra(smooth_cfg_reg.global_smoothing_extra_stretch),
        .scaled_time(smooth_time_remote1)
    );
    smooth_scale u_scale_loc (
        .pclk(pclk), .presetn(presetn), .ce(ce), .base_time(base_time_local),
        .slow(smooth_cfg_reg.slow[1]),
        .extra(smooth_cfg_reg.global_smoothing_extra_stretch),
        .scaled_time(smooth_time_local)
    );
    smooth_scale u_scale_r2 (
        .pclk(pclk), .presetn(presetn), .ce(ce), .base_time(base_time_remote2),
        .slow(smooth_cfg_reg.slow[2]),
        .extra(smooth_cfg_reg.global_smoothing_extra_stretch),
        .scaled_time(smooth_time_remote2)
    );

    // Checks on the design's own behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    hyst_lock_hold_a: assert property (
        lock_reg && $stable(lock_reg) |=> $stable(hyst_cfg_reg))
        else $error("hysteresis register changed while locked");
    hyst_out_a: assert property (
        ce |=> overtemp_hysteresis_on == !$past(hyst_cfg_reg[0]))
        else $error("hysteresis output disagrees with register");
    reserved_zero_a: assert property (
        (smooth_cfg_reg & ~SMOOTH_WMASK) == '0 && hyst_cfg_reg[7:1] == '0)
        else $error("reserved bits stored");
    manual_gate_a: assert property (
        ce && ot_pin_s && manual_s && !smooth_cfg_reg.overtemp_in_manual_mode |=> !fan_override)
        else $error("overtemp acted in manual mode while disallowed");
    override_a: assert property (
        ce && ot_pin_s && !manual_s |=> fan_override)
        else $error("overtemp did not override fans");
    core_low_flag_a: assert property (
        ce && core_low_event |=> status_reg[ST_CORE_LOW])
        else $error("core-low status not set");
    processor_hot_monitor_off_a: assert property (
        ce && mon_state_reg == MON_CORE_LOW |=> !processor_hot_monitor)
        else $error("processor-hot monitor not suspended");
    spinup_entry_a: assert property (
        ce && mon_state_reg == MON_CORE_LOW && !core_low_s |=> mon_state_reg == MON_SPINUP)
        else $error("no spin-up after core recovery");
    irq_level_a: assert property (
        ce |=> irq == $past(|(status_reg & mask_reg)))
        else $error("interrupt output wrong");

    // Register writes land, the lock cannot be undone short of reset, manual-mode overtemp acts when allowed, and core-low and spin-up states step
    lock_sticky_a: assert property (
        lock_reg |=> lock_reg)
        else $error("lock bit cleared without reset");
    hyst_write_a: assert property (
        wr_en && index == IDX_HYST_CFG && !lock_reg
            |=> hyst_cfg_reg == $past(pwdata[7:0] & HYST_WMASK))
        else $error("unlocked hysteresis write lost");
    smooth_write_a: assert property (
        wr_en && index == IDX_SMOOTH_CFG
            |=> smooth_cfg_reg == $past(pwdata[7:0] & SMOOTH_WMASK))
        else $error("configuration write lost");
    ot_manual_on_a: assert property (
        ce && ot_pin_s && smooth_cfg_reg.overtemp_in_manual_mode |=> fan_override)
        else $error("overtemp ignored in manual mode while allowed");
    core_low_entry_a: assert property (
        ce && mon_state_reg == MON_RUN && core_low_event |=> mon_state_reg == MON_CORE_LOW)
        else $error("core-low did not suspend monitoring");
    spinup_out_a: assert property (
        ce && mon_state_reg == MON_SPINUP |=> fan_spinup && processor_hot_monitor)
        else $error("spin-up not shown or monitoring still off");
    spinup_exit_a: assert property (
        ce && mon_state_reg == MON_SPINUP && spin_cnt_reg == '0 && !core_low_event
            |=> mon_state_reg == MON_RUN)
        else $error("spin-up did not end");
endmodule : fan_smoothing_overtemp_config

/* File: bench/fan_smoothing_overtemp_config_bench.sv */
`timescale 1ns/1ps
module fan_smoothing_overtemp_config_bench
    import fan_cfg_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic overtemp_pin = 1'b0;
    logic manual_mode = 1'b0;
    logic standby_power = 1'b0;
    logic core_voltage_low = 1'b0;
    logic [BASE_W-1:0] base_time = 8'h64;
    logic [31:0] prdata;
    logic pready, pslverr, fan_override, overtemp_hysteresis_on;
    logic processor_hot_monitor, fan_spinup, irq;
    logic [SCALED_W-1:0] st [NUM_CH];
    logic [31:0] rd;
    logic err;
    int failures = 0;
    int comparisons = 0;

    // Free-running bus clock, 100 MHz
    always #5 pclk = ~pclk;

    // Short spin-up so the recovery walk fits in a few cycles
    fan_smoothing_overtemp_config #(.SPINUP_LEN(8)) i_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .base_time_remote1(base_time),
        .base_time_local(base_time), .base_time_remote2(base_time),
        .overtemp_pin(overtemp_pin), .manual_mode(manual_mode),
        .standby_power(standby_power), .core_voltage_low(core_voltage_low),
        .smooth_time_remote1(st[0]), .smooth_time_local(st[1]),
        .smooth_time_remote2(st[2]), .fan_override(fan_override),
        .overtemp_hysteresis_on(overtemp_hysteresis_on),
        .processor_hot_monitor(processor_hot_monitor), .fan_spinup(fan_spinup), .irq(irq)
    );

    task automatic complete_run();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Settle after an edge so registered outputs have landed
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : wait_cyc

    // One APB transfer; waits for pready at a rising edge, only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
        check(32'(err), 32'h0);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(rd, exp);
    endtask : rd_chk

    task automatic test_reset();
        rd_chk(IDX_SMOOTH_CFG, 32'h0);
        rd_chk(IDX_HYST_CFG, 32'h0);
        check(32'(overtemp_hysteresis_on), 32'h1);
        check(32'(processor_hot_monitor), 32'h1);
        check(32'(irq), 32'h0);
        $display("test reset done");
    endtask : test_reset

    // Base time 100: x4 gives 400, x1.392 gives 139, both give 556
    task automatic test_stretch();
        for (int i = 0; i < NUM_CH; i++) begin
            wr(IDX_SMOOTH_CFG, 32'(8'h01 << i));
            wait_cyc(3);
            for (int c = 0; c < NUM_CH; c++) begin
                check(32'(st[c]), (c == i) ? 32'h190 : 32'h064);
            end
        end
        wr(IDX_SMOOTH_CFG, 32'h80);
        wait_cyc(3);
        for (int c = 0; c < NUM_CH; c++) check(32'(st[c]), 32'h08b);
        wr(IDX_SMOOTH_CFG, 32'h87);
        wait_cyc(3);
        for (int c = 0; c < NUM_CH; c++) check(32'(st[c]), 32'h22c);
        wr(IDX_SMOOTH_CFG, 32'hff);
        rd_chk(IDX_SMOOTH_CFG, 32'hcf);
        wr(IDX_SMOOTH_CFG, 32'h00);
        $display("test stretch done");
    endtask : test_stretch

    task automatic test_overtemp();
        wr(IDX_IRQ_MASK, 32'h1);
        @(posedge pclk);
        overtemp_pin <= 1'b1;
        wait_cyc(5);
        check(32'(fan_override), 32'h1);
        check(32'(irq), 32'h1);
        @(posedge pclk);
        manual_mode <= 1'b1;
        wait_cyc(5);
        check(32'(fan_override), 32'h0);
        wr(IDX_SMOOTH_CFG, 32'h08);
        wait_cyc(3);
        check(32'(fan_override), 32'h1);
        wr(IDX_IRQ_MASK, 32'h0);
        wait_cyc(2);
        check(32'(irq), 32'h0);
        @(posedge pclk);
        overtemp_pin <= 1'b0;
        manual_mode <= 1'b0;
        wait_cyc(5);
        check(32'(fan_override), 32'h0);
        wr(IDX_IRQ_STATUS, 32'h1);
        rd_chk(IDX_IRQ_STATUS, 32'h0);
        wr(IDX_SMOOTH_CFG, 32'h00);
        $display("test overtemp done");
    endtask : test_overtemp

    task automatic test_core_low();
        int n;
        wr(IDX_SMOOTH_CFG, 32'h40);
        wr(IDX_IRQ_MASK, 32'h2);
        // Mains powered: the condition must be ignored
        @(posedge pclk);
        core_voltage_low <= 1'b1;
        wait_cyc(6);
        check(32'(processor_hot_monitor), 32'h1);
        rd_chk(IDX_IRQ_STATUS, 32'h0);
        @(posedge pclk);
        standby_power <= 1'b1;
        wait_cyc(6);
        check(32'(processor_hot_monitor), 32'h0);
        check(32'(irq), 32'h1);
        rd_chk(IDX_IRQ_STATUS, 32'h2);
        rd_chk(IDX_STATE, 32'h1);
        @(posedge pclk);
        core_voltage_low <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (fan_spinup !== 1'b1 && n < 20);
        n = 0;
        while (fan_spinup === 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        check(32'(n), 32'h8);
        wait_cyc(2);
        check(32'(processor_hot_monitor), 32'h1);
        wr(IDX_IRQ_STATUS, 32'h2);
        wait_cyc(2);
        check(32'(irq), 32'h0);
        @(posedge pclk);
        standby_power <= 1'b0;
        $display("test core low done");
    endtask : test_core_low

    task automatic test_lock();
        apb(1'b0, 8'h1f, 32'h0);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        wr(IDX_HYST_CFG, 32'h01);
        wait_cyc(2);
        check(32'(overtemp_hysteresis_on), 32'h0);
        wr(IDX_HYST_CFG, 32'hff);
        rd_chk(IDX_HYST_CFG, 32'h1);
        wr(IDX_LOCK, 32'h1);
        wr(IDX_HYST_CFG, 32'h00);
        wait_cyc(2);
        rd_chk(IDX_HYST_CFG, 32'h1);
        check(32'(overtemp_hysteresis_on), 32'h0);
        // Reset in mid-run clears both registers and releases the lock
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(IDX_HYST_CFG, 32'h0);
        rd_chk(IDX_SMOOTH_CFG, 32'h0);
        check(32'(overtemp_hysteresis_on), 32'h1);
        wr(IDX_HYST_CFG, 32'h01);
        rd_chk(IDX_HYST_CFG, 32'h1);
        $display("test lock done");
    endtask : test_lock

    // Clock enable low freezes the pin path; the override follows once it returns
    task automatic test_freeze();
        @(posedge pclk);
        ce <= 1'b0;
        overtemp_pin <= 1'b1;
        wait_cyc(5);
        check(32'(fan_override), 32'h0);
        @(posedge pclk);
        ce <= 1'b1;
        wait_cyc(5);
        check(32'(fan_override), 32'h1);
        @(posedge pclk);
        overtemp_pin <= 1'b0;
        wait_cyc(5);
        check(32'(fan_override), 32'h0);
        wr(IDX_IRQ_STATUS, 32'h1);
        rd_chk(IDX_IRQ_STATUS, 32'h0);
        $display("test freeze done");
    endtask : test_freeze

    // Main sequence; lock goes last since only reset clears it
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_stretch();
        test_overtemp();
        test_core_low();
        test_freeze();
        test_lock();
        complete_run();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #100us;
        failures++;
        complete_run();
    end
endmodule : fan_smoothing_overtemp_config_bench
